//--- common/splc_pkg.sv
// Package of constants and types for the stack pointer limit checker.
// ****************************************************************************
// Overview of operation
// - Last working register doubles as the software stack pointer.
// - Pointer holds next free word address; stack grows upward.
// - Push writes then increments; pop decrements then reads.
// - Call push zero-fills the word above the full counter upper part.
// - Exception push joins status low byte onto counter upper part.
// - A stack limit register holds the highest usable stack address.
// - The stack limit register gets no value from any reset.
// - Bit zero of the stack limit reads as zero after the first limit write.
// - Every stack pointer based effective address is checked against the lower bound; only pushes against the limit.
// - A push made with pointer equal to limit raises no error.
// - The next push past the limit raises a stack error.
// - Pointer addresses below 0x0800 raise an underflow stack error.
// ****************************************************************************
package splc_pkg;
  localparam int SPLC_DW = 16;
  localparam logic [15:0] SPLC_UNDERFLOW_BOUND = 16'h0800;
  localparam logic [15:0] SPLC_WORD_STEP = 16'h0002;
  localparam logic [15:0] SPLC_SP_RESET = 16'h0800;
  localparam int SPLC_PC_UPPER_W = 7;
  localparam int SPLC_STATUS_LOW_W = 8;
  typedef enum logic [2:0]
  {
    SPLC_OP_NONE = 3'h0,
    SPLC_OP_PUSH = 3'h1,
    SPLC_OP_POP = 3'h2,
    SPLC_OP_CALL = 3'h3,
    SPLC_OP_EXC = 3'h4,
    SPLC_OP_EA = 3'h5,
    SPLC_OP_WRSP = 3'h6
  } splc_op_t;
endpackage : splc_pkg

//--- rtl/splc_limit_cmp.sv
// Comparator that classifies one stack effective address against the bounds.
`timescale 1ns/1ps
module splc_limit_cmp
  import splc_pkg::*;
(
  input wire logic [15:0] ea_i, // Effective address under test
  input wire logic [15:0] limit_i, // Word-aligned stack limit
  input wire logic is_push_i, // Access is a push
  output logic overflow_o, // Address beyond the limit
  output logic underflow_o // Address below the lower bound
);
  // A push at the limit address itself is allowed; only beyond it faults.
  assign overflow_o = (ea_i > limit_i) && is_push_i;
  assign underflow_o = ea_i < SPLC_UNDERFLOW_BOUND;
endmodule : splc_limit_cmp

//--- rtl/splc_stack_checker.sv
// Stack pointer, push formatting and stack limit checking for the core.
`timescale 1ns/1ps
module splc_stack_checker
  import splc_pkg::*;
(
  input wire logic mclk_i, // Core clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic [2:0] op_i, // Stack operation this cycle
  input wire logic [15:0] data_i, // Data to push or pointer write value
  input wire logic [15:0] ea_i, // Effective address for general pointer use
  input wire logic [6:0] pc_upper_i, // Program counter upper part
  input wire logic [7:0] status_low_byte_i, // Low status byte
  input wire logic limit_we_i, // Stack limit register write strobe
  input wire logic [15:0] limit_wdata_i, // Stack limit write data
  output logic [15:0] stack_pointer_reg_o, // Current stack pointer
  output logic [15:0] stack_limit_reg_o, // Stack limit read value
  output logic mem_we_o, // Stack memory write strobe
  output logic mem_re_o, // Stack memory read strobe
  output logic [15:0] mem_addr_o, // Stack memory address
  output logic [15:0] mem_wdata_o, // Stack memory write data
  output logic stack_error_o // One-cycle stack error event
);
  // **************************************************************************
  // State
  // **************************************************************************
  typedef struct packed
  {
    logic [15:0] sp;
    logic we;
    logic re;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic err;
  } splc_state_t;

  splc_state_t st;
  splc_state_t next_st;
  // The limit has no reset by design, so it lives outside the reset struct.
  logic [15:0] stack_limit_reg;
  logic [15:0] chk_ea;
  logic is_push;
  logic is_pop;
  logic is_check;
  logic ovf;
  logic unf;
  splc_op_t op;

  assign op = splc_op_t'(op_i);
  assign is_push = (op == SPLC_OP_PUSH) || (op == SPLC_OP_CALL) || (op == SPLC_OP_EXC);
  assign is_pop = op == SPLC_OP_POP;
  assign is_check = is_push || is_pop || (op == SPLC_OP_EA);
  // Pops are checked at the pre-decremented address.
  assign chk_ea = is_pop ? (st.sp - SPLC_WORD_STEP) : (op == SPLC_OP_EA ? ea_i : st.sp);

  splc_limit_cmp u_cmp
  (
    .ea_i(chk_ea),
    .limit_i(stack_limit_reg),
    .is_push_i(is_push),
    .overflow_o(ovf),
    .underflow_o(unf)
  );

  always_ff @(posedge mclk_i)
  begin
    if (limit_we_i)
    begin
      stack_limit_reg <= {limit_wdata_i[15:1], 1'b0};
    end
  end

  // **************************************************************************
  // Next state
  // **************************************************************************
  always_comb
  begin
    next_st = st;
    next_st.we = 1'b0;
    next_st.re = 1'b0;
    next_st.err = 1'b0;
    case (op)
      SPLC_OP_PUSH:
      begin
        next_st.addr = st.sp;
        next_st.wdata = data_i;
        next_st.we = 1'b1;
        next_st.sp = st.sp + SPLC_WORD_STEP;
      end
      SPLC_OP_CALL:
      begin
        next_st.addr = st.sp;
        next_st.wdata = {9'h000, pc_upper_i};
        next_st.we = 1'b1;
        next_st.sp = st.sp + SPLC_WORD_STEP;
      end
      SPLC_OP_EXC:
      begin
        next_st.addr = st.sp;
        next_st.wdata = {status_low_byte_i, 1'b0, pc_upper_i};
        next_st.we = 1'b1;
        next_st.sp = st.sp + SPLC_WORD_STEP;
      end
      SPLC_OP_POP:
      begin
        next_st.sp = st.sp - SPLC_WORD_STEP;
        next_st.addr = st.sp - SPLC_WORD_STEP;
        next_st.re = 1'b1;
      end
      SPLC_OP_WRSP:
      begin
        next_st.sp = {data_i[15:1], 1'b0};
      end
      default:
      begin
        next_st.sp = st.sp;
      end
    endcase
    next_st.err = is_check && (ovf || unf);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '{sp: SPLC_SP_RESET, we: 1'b0, re: 1'b0, addr: 16'h0000,
              wdata: 16'h0000, err: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // The limit output is registered from the limit itself, one cycle behind,
  // which is why a limit read right after a limit write is discouraged.
  always_ff @(posedge mclk_i)
  begin
    stack_limit_reg_o <= stack_limit_reg;
  end

  assign stack_pointer_reg_o = st.sp;
  assign mem_we_o = st.we;
  assign mem_re_o = st.re;
  assign mem_addr_o = st.addr;
  assign mem_wdata_o = st.wdata;
  assign stack_error_o = st.err;

  // **************************************************************************
  // Assertions
  // **************************************************************************
  property p_push_inc;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h1) |=> (stack_pointer_reg_o == $past(stack_pointer_reg_o) + 16'h0002)
      && mem_we_o && (mem_addr_o == $past(stack_pointer_reg_o));
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push pointer wrong");

  property p_pop_dec;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h2) |=> mem_re_o && (mem_addr_o == stack_pointer_reg_o)
      && (stack_pointer_reg_o == $past(stack_pointer_reg_o) - 16'h0002);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop pointer wrong");

  property p_call_msb;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h3) |=> (mem_wdata_o[15:7] == 9'h000) && mem_we_o;
  endproperty
  a_call_msb: assert property (p_call_msb) else $error("call push not cleared");

  property p_exc_status;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h4) |=> (mem_wdata_o[15:8] == $past(status_low_byte_i));
  endproperty
  a_exc_status: assert property (p_exc_status) else $error("exception push lacks status");

  property p_limit_even;
    @(posedge mclk_i) limit_we_i |=> (stack_limit_reg[0] == 1'b0);
  endproperty
  a_limit_even: assert property (p_limit_even) else $error("limit bit zero set");

  property p_at_limit_ok;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h1 && stack_pointer_reg_o == stack_limit_reg
      && stack_pointer_reg_o >= 16'h0800) |=> !stack_error_o;
  endproperty
  a_at_limit_ok: assert property (p_at_limit_ok) else $error("error at limit");

  property p_past_limit;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h1 && stack_pointer_reg_o > stack_limit_reg) |=> stack_error_o;
  endproperty
  a_past_limit: assert property (p_past_limit) else $error("overflow missed");

  property p_underflow;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (op_i == 3'h5 && ea_i < 16'h0800) |=> stack_error_o;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow missed");

  property p_err_pulse;
    @(posedge mclk_i) disable iff (!reset_n_i)
    stack_error_o |-> $past(op_i != 3'h0 && op_i != 3'h6);
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error without access");
endmodule : splc_stack_checker

//--- verif/splc_mem_model.sv
// Behavioural stack memory that stands on the memory side of the checker.
`timescale 1ns/1ps
module splc_mem_model
(
  input wire logic mclk_i, // Core clock
  input wire logic we_i, // Write strobe
  input wire logic re_i, // Read strobe
  input wire logic [15:0] addr_i, // Word address
  input wire logic [15:0] wdata_i, // Write data
  output logic [15:0] rdata_o // Read data, valid the cycle after a read
);
  // A plain word array keeps the model within reach of the simpler simulators.
  logic [15:0] mem [0:32767];
  bit written [0:32767];
  initial rdata_o = 16'h0000;
  // An unwritten word reads as the inverse of the last value, never a stale match.
  always @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem[addr_i[15:1]] <= wdata_i;
      written[addr_i[15:1]] <= 1'b1;
    end
    if (re_i)
      rdata_o <= written[addr_i[15:1]] ? mem[addr_i[15:1]] : ~rdata_o;
  end
endmodule : splc_mem_model

//--- verif/testbench.sv
// Self-checking bench for the stack pointer limit checker.
`timescale 1ns/1ps
module testbench;
  import splc_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [15:0] data_i = 16'h0000;
  logic [15:0] ea_i = 16'h0000;
  logic [6:0] pc_upper_i = 7'h00;
  logic [7:0] status_low_byte_i = 8'h00;
  logic limit_we_i = 1'b0;
  logic [15:0] limit_wdata_i = 16'h0000;
  logic [15:0] sp, lim, addr, wdata, rdata;
  logic we, re, err;
  int n_errors = 0;
  int checks = 0;
  always #50 mclk_i = ~mclk_i;
  splc_stack_checker u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .op_i(op_i),
    .data_i(data_i), .ea_i(ea_i), .pc_upper_i(pc_upper_i),
    .status_low_byte_i(status_low_byte_i), .limit_we_i(limit_we_i),
    .limit_wdata_i(limit_wdata_i), .stack_pointer_reg_o(sp), .stack_limit_reg_o(lim),
    .mem_we_o(we), .mem_re_o(re), .mem_addr_o(addr), .mem_wdata_o(wdata),
    .stack_error_o(err));
  splc_mem_model u_mem (.mclk_i(mclk_i), .we_i(we), .re_i(re), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0, got}, {15'h0, exp});
  endtask : chk1
  task automatic run_op(input logic [2:0] op, input logic [15:0] d);
    @(posedge mclk_i);
    op_i <= op;
    data_i <= d;
    @(posedge mclk_i);
    op_i <= SPLC_OP_NONE;
    #1;
  endtask : run_op
  // The pause after a limit write keeps limit reads clear of the stale limit.
  task automatic set_limit(input logic [15:0] v);
    @(posedge mclk_i);
    limit_we_i <= 1'b1;
    limit_wdata_i <= v;
    @(posedge mclk_i);
    limit_we_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : set_limit
  task automatic chk_acc(input logic w, r, e, input logic [15:0] a, s);
    chk1(we, w);
    chk1(re, r);
    chk1(err, e);
    chk16(addr, a);
    chk16(sp, s);
  endtask : chk_acc
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_limit();
    chk16(sp, 16'h0800);
    chk1(err, 1'b0);
    chk16(lim, 16'hXXXX);
    set_limit(16'h0805);
    chk16(lim, 16'h0804);
    $display("test reset_limit done");
  endtask : t_reset_limit
  task automatic t_push_pop();
    for (int i = 0; i < 4; i++)
    begin
      run_op(SPLC_OP_PUSH, 16'hA000 + 16'(i));
      chk_acc(1'b1, 1'b0, i == 3, 16'h0800 + 16'(2 * i), 16'h0802 + 16'(2 * i));
      chk16(wdata, 16'hA000 + 16'(i));
      @(posedge mclk_i);
      #1;
      chk1(err, 1'b0);
    end
    for (int i = 3; i >= 0; i--)
    begin
      run_op(SPLC_OP_POP, 16'h0000);
      chk_acc(1'b0, 1'b1, 1'b0, 16'h0800 + 16'(2 * i), 16'h0800 + 16'(2 * i));
      @(posedge mclk_i);
      #1;
      chk16(rdata, 16'hA000 + 16'(i));
    end
    run_op(SPLC_OP_POP, 16'h0000);
    chk_acc(1'b0, 1'b1, 1'b1, 16'h07FE, 16'h07FE);
    $display("test push_pop done");
  endtask : t_push_pop
  task automatic t_frames();
    set_limit(16'h0FFE);
    run_op(SPLC_OP_WRSP, 16'h0901);
    chk16(sp, 16'h0900);
    @(posedge mclk_i);
    pc_upper_i <= 7'h7F;
    status_low_byte_i <= 8'hA5;
    run_op(SPLC_OP_CALL, 16'h0000);
    chk_acc(1'b1, 1'b0, 1'b0, 16'h0900, 16'h0902);
    chk16(wdata, 16'h007F);
    run_op(SPLC_OP_EXC, 16'h0000);
    chk16(wdata, 16'hA57F);
    chk16(sp, 16'h0904);
    $display("test frames done");
  endtask : t_frames
  task automatic t_ea();
    logic [15:0] eas [3] = '{16'h07FE, 16'h0800, 16'h1000};
    logic exp_err [3] = '{1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk_i);
      ea_i <= eas[i];
      run_op(SPLC_OP_EA, 16'h0000);
      chk1(err, exp_err[i]);
      chk1(we, 1'b0);
    end
    $display("test ea done");
  endtask : t_ea
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    #1;
    t_reset_limit();
    t_push_pop();
    t_frames();
    t_ea();
    tally_and_finish();
  end
  // The run needs about fifty cycles; forty times that means a hang.
  initial
  begin
    repeat (2000) @(posedge mclk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule : testbench
